// *** hcur_fetch.sv ***
// Pattern line fetch sequencer: one memory request per cursor line.
// Assumes memory returns exactly one rvalid per request, same clock.
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Line fetch
// ****************************************************************
module hcur_fetch (
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    input  wire logic [15:0] start_addr,  // Pattern start register
    input  wire logic        pitch_2k,    // Line pitch select
    input  wire logic        line_go,     // New cursor line needed
    input  wire logic [5:0]  line_row,    // Pattern row to fetch
    input  wire logic        mem_rvalid,  // Line data returned
    output logic             mem_req,     // One-cycle request pulse
    output logic [21:0]      mem_addr,    // Registered line address
    output logic             busy         // Waiting for line data
);
    typedef enum logic {HF_IDLE, HF_WAIT} hcur_fst_t;
    typedef struct packed {
        hcur_fst_t   st;
        logic        req;
        logic [21:0] addr;
    } hcur_fetch_t;

    hcur_fetch_t s, next_s;  // Whole state and its next value

    // A new line request restarts the fetch even mid-wait
    always_comb begin
        next_s = s;
        next_s.req = 1'b0;
        case (s.st)
            HF_IDLE: begin
                if (line_go) begin
                    next_s.st = HF_WAIT;
                end
            end
            HF_WAIT: begin
                if (mem_rvalid && !line_go) begin
                    next_s.st = HF_IDLE;
                end
            end
            default: begin
                next_s.st = HF_IDLE;
            end
        endcase
        if (line_go) begin
            next_s.req  = 1'b1;
            next_s.addr = hcur_pkg::line_addr(start_addr, pitch_2k, line_row);
        end
    end

    // State register
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign mem_req  = s.req;
    assign mem_addr = s.addr;
    assign busy     = (s.st == HF_WAIT);

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    a_fetch_16b: assert property (line_go && !pitch_2k |=> mem_req &&
        mem_addr == {$past(start_addr[15:4]), $past(line_row), 4'h0})
        else $error("16-byte pitch line address wrong");
    a_fetch_2k: assert property (line_go && pitch_2k |=> mem_req &&
        mem_addr[21:17] == $past(start_addr[15:11]) &&
        mem_addr[10:6] == $past(start_addr[4:0]) && mem_addr[5:0] == 6'h00)
        else $error("2048-byte pitch line address wrong");
    a_fetch_busy: assert property (line_go |=> busy)
        else $error("fetch did not wait for data");
endmodule
`default_nettype wire

// *** hcur_mem_model.sv ***
// Pattern memory model that answers cursor line fetches.
// Assumes at most one request outstanding, all on clk_sys.
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Memory model
// ****************************************************************
module hcur_mem_model (
    input  wire logic         clk_sys,
    input  wire logic         mem_req,    // Line request pulse
    input  wire logic [127:0] pat,        // Line contents to return
    input  wire logic         slow,       // Long answer delay
    output logic              mem_rvalid, // Data valid pulse
    output logic [127:0]      mem_rdata   // Pattern line
);
    int wait_n = -1;                      // Cycles to the answer, -1 idle
    // One answer per request; data toggles outside the valid cycle
    // so a design that samples it one cycle late never sees a stale match
    always @(posedge clk_sys) begin
        mem_rvalid <= 1'b0;
        mem_rdata  <= ~mem_rdata;
        if (mem_req) begin
            wait_n <= slow ? 6 : 0;
        end else if (wait_n == 0) begin
            mem_rvalid <= 1'b1;
            mem_rdata  <= pat;
            wait_n     <= -1;
        end else if (wait_n > 0) begin
            wait_n <= wait_n - 1;
        end
    end
endmodule
`default_nettype wire

// *** hcur_pkg.sv ***
// Shared constants, field layouts and helpers for the hardware cursor block.
// Assumes a single 20 MHz clock domain shared by host port and pixel path.
// ****************************************************************
// Register map and fields
// ****************************************************************
package hcur_pkg;
    localparam logic [7:0]  OFS_XFER   = 8'h80;  // Host data transfer port
    localparam logic [7:0]  OFS_START  = 8'h84;  // Pattern start address
    localparam logic [7:0]  OFS_HOT    = 8'h88;  // Hotspot offset
    localparam logic [7:0]  OFS_XPOS   = 8'h8C;  // Screen column
    localparam logic [7:0]  OFS_YPOS   = 8'h90;  // Screen row
    localparam logic [7:0]  OFS_PRI_LO = 8'h94;  // Primary colour low
    localparam logic [7:0]  OFS_PRI_HI = 8'h98;  // Primary high and control
    localparam logic [7:0]  OFS_SEC_LO = 8'h9C;  // Secondary colour low
    localparam logic [15:0] RST16      = 16'h0000;
    localparam logic [31:0] RST32      = 32'h00000000;
    localparam logic [15:0] HOT_MASK   = 16'h3F3F;  // Reserved bits read zero
    localparam logic [15:0] POS_MASK   = 16'h07FF;
    localparam logic [15:0] PRI_HI_MASK = 16'hC0FF;
    localparam int          PITCH_BIT  = 14;        // 0: 16-byte, 1: 2048-byte
    localparam int          ENABLE_BIT = 15;        // Cursor display on
    localparam int          ADDR_W     = 22;        // Display memory byte address
    localparam int          LINE_BITS  = 128;       // 64 pixels of 2 bits
    localparam logic [1:0]  CODE_PRI   = 2'h0;
    localparam logic [1:0]  CODE_SEC   = 2'h1;
    localparam logic [1:0]  CODE_TRN   = 2'h2;
    localparam logic [1:0]  CODE_INV   = 2'h3;
    localparam logic [1:0]  MODE_8     = 2'h0;
    localparam logic [1:0]  MODE_16    = 2'h1;

    // Byte address of one pattern line for either pitch
    function automatic logic [21:0] line_addr(input logic [15:0] st,
                                              input logic       p2k,
                                              input logic [5:0] row);
        if (p2k)
            line_addr = {st[15:11], row, st[4:0], 6'h00};
        else
            line_addr = {st[15:4], row, 4'h0};
    endfunction

    // Pixel index relative to the pattern edge; inside when bits 12:6 are zero
    function automatic logic [12:0] rel_pos(input logic [10:0] pix,
                                            input logic [10:0] pos,
                                            input logic [5:0]  hot);
        rel_pos = {2'h0, pix} + {7'h00, hot} - {2'h0, pos};
    endfunction

    // Colour limited to the active depth
    function automatic logic [23:0] depth_mask(input logic [23:0] c,
                                               input logic [1:0]  mode);
        if (mode == MODE_8)
            depth_mask = {16'h0000, c[7:0]};
        else if (mode == MODE_16)
            depth_mask = {8'h00, c[15:0]};
        else
            depth_mask = c;
    endfunction
endpackage

// *** hcur_top.sv ***
// Hardware cursor register set, host data port and cursor pixel overlay.
// Assumes host port, memory and pixel stream all run on clk_sys.
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Top module
// ****************************************************************
module hcur_top (
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    input  wire logic [7:0]  reg_addr,      // Register byte offset
    input  wire logic        reg_wr,        // Write strobe
    input  wire logic        reg_rd,        // Read strobe
    input  wire logic [31:0] reg_wdata,     // Write data
    output logic [31:0]      reg_rdata,     // Read data
    output logic             reg_ack,       // Access done
    output logic             xfer_wr,       // Host word to drawing engine
    output logic [31:0]      xfer_data,     // Host data port contents
    input  wire logic        xfer_load,     // Engine returns image word
    input  wire logic [31:0] xfer_load_data,
    input  wire logic        three_color_en, // Code 11 shows auxiliary
    input  wire logic        exchange_colors,// Swap primary and secondary
    input  wire logic [23:0] aux_color,     // Auxiliary colour
    input  wire logic [7:0]  sec_color_high,// Secondary bits 16-23
    input  wire logic [1:0]  color_mode,    // 0: 8, 1: 16, else 24 bits
    output logic             mem_req,       // Pattern line request
    output logic [21:0]      mem_addr,      // Pattern line address
    input  wire logic        mem_rvalid,    // Line data valid
    input  wire logic [127:0] mem_rdata,    // 64 pixels, pixel 0 in bits 1:0
    input  wire logic        line_start,    // Pulse before each screen line
    input  wire logic [10:0] line_y,        // Row of the coming line
    input  wire logic        pix_valid,     // Screen pixel in
    input  wire logic [10:0] pix_x,         // Its column
    input  wire logic [23:0] pix_in,        // Its colour
    output logic             pix_out_valid, // Pixel out, one cycle later
    output logic [23:0]      pix_out        // Overlaid colour
);
    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [31:0]  xfer;     // Host data port word
        logic [15:0]  start;    // Pattern start address
        logic [15:0]  hot;      // Hotspot offsets
        logic [15:0]  xpos;     // Cursor column
        logic [15:0]  ypos;     // Cursor row
        logic [15:0]  pri_lo;   // Primary colour low
        logic [15:0]  pri_hi;   // Primary high and control
        logic [15:0]  sec_lo;   // Secondary colour low
        logic [31:0]  rdata;    // Read answer
        logic         ack;      // Access answer
        logic         xfer_wr;  // Host data strobe
        logic [127:0] line;     // Current pattern line
        logic         line_ok;  // Line valid for this screen line
        logic [23:0]  pix;      // Overlaid pixel
        logic         pix_v;    // Pixel valid
    } hcur_state_t;

    hcur_state_t s, next_s;

    logic        fetch_busy;  // Fetch waiting for memory
    logic        line_go;     // Start a pattern line fetch
    logic [12:0] rel_y;       // Screen row relative to pattern top
    logic [12:0] rel_x;       // Screen column relative to pattern left
    logic        row_in;      // Coming line crosses the pattern
    logic        hit;         // Pixel lies on the pattern
    logic [1:0]  code;        // Raw pattern code
    logic [1:0]  eff_code;    // Code after exchange
    logic [23:0] pri_c;       // Depth-limited primary
    logic [23:0] sec_c;       // Depth-limited secondary
    logic [23:0] aux_c;       // Depth-limited auxiliary
    logic [23:0] inv_c;       // Depth-limited inverse of the screen
    logic        cur_on;      // Cursor display on

    // ************************************************************
    // Window and pattern decode
    // ************************************************************
    // Hotspot moves the pattern so that its hot pixel sits on the position
    always_comb begin
        cur_on = s.pri_hi[hcur_pkg::ENABLE_BIT];
        rel_y  = hcur_pkg::rel_pos(line_y, s.ypos[10:0], s.hot[13:8]);
        rel_x  = hcur_pkg::rel_pos(pix_x, s.xpos[10:0], s.hot[5:0]);
        row_in = (rel_y[12:6] == 7'h00);
        line_go = line_start && cur_on && row_in;
        hit    = cur_on && s.line_ok && (rel_x[12:6] == 7'h00);
        code   = s.line[{rel_x[5:0], 1'b0} +: 2];
        eff_code = code;
        if (exchange_colors && !code[1]) begin
            eff_code = {1'b0, ~code[0]};
        end
        pri_c = hcur_pkg::depth_mask({s.pri_hi[7:0], s.pri_lo}, color_mode);
        sec_c = hcur_pkg::depth_mask({sec_color_high, s.sec_lo}, color_mode);
        aux_c = hcur_pkg::depth_mask(aux_color, color_mode);
        inv_c = hcur_pkg::depth_mask(~pix_in, color_mode);
    end

    // ************************************************************
    // Next state
    // ************************************************************
    // Register writes, read answer, line capture and pixel overlay
    always_comb begin
        next_s = s;
        next_s.ack = reg_wr || reg_rd;
        next_s.xfer_wr = 1'b0;
        // Engine load first so that a host write in the same cycle wins
        if (xfer_load) begin
            next_s.xfer = xfer_load_data;
        end
        if (reg_wr) begin
            case (reg_addr)
                hcur_pkg::OFS_XFER: begin
                    next_s.xfer    = reg_wdata;
                    next_s.xfer_wr = 1'b1;
                end
                hcur_pkg::OFS_START: begin
                    next_s.start = reg_wdata[15:0];
                end
                hcur_pkg::OFS_HOT: begin
                    next_s.hot = reg_wdata[15:0] & hcur_pkg::HOT_MASK;
                end
                hcur_pkg::OFS_XPOS: begin
                    next_s.xpos = reg_wdata[15:0] & hcur_pkg::POS_MASK;
                end
                hcur_pkg::OFS_YPOS: begin
                    next_s.ypos = reg_wdata[15:0] & hcur_pkg::POS_MASK;
                end
                hcur_pkg::OFS_PRI_LO: begin
                    next_s.pri_lo = reg_wdata[15:0];
                end
                hcur_pkg::OFS_PRI_HI: begin
                    next_s.pri_hi = reg_wdata[15:0] & hcur_pkg::PRI_HI_MASK;
                end
                hcur_pkg::OFS_SEC_LO: begin
                    next_s.sec_lo = reg_wdata[15:0];
                end
                default: begin
                    // Unmapped writes are dropped
                end
            endcase
        end
        // Read answer; unmapped offsets read zero
        if (reg_rd) begin
            case (reg_addr)
                hcur_pkg::OFS_XFER:   next_s.rdata = s.xfer;
                hcur_pkg::OFS_START:  next_s.rdata = {16'h0000, s.start};
                hcur_pkg::OFS_HOT:    next_s.rdata = {16'h0000, s.hot};
                hcur_pkg::OFS_XPOS:   next_s.rdata = {16'h0000, s.xpos};
                hcur_pkg::OFS_YPOS:   next_s.rdata = {16'h0000, s.ypos};
                hcur_pkg::OFS_PRI_LO: next_s.rdata = {16'h0000, s.pri_lo};
                hcur_pkg::OFS_PRI_HI: next_s.rdata = {16'h0000, s.pri_hi};
                hcur_pkg::OFS_SEC_LO: next_s.rdata = {16'h0000, s.sec_lo};
                default:              next_s.rdata = hcur_pkg::RST32;
            endcase
        end
        // A new screen line invalidates the old pattern line first
        if (line_start) begin
            next_s.line_ok = 1'b0;
        end else if (mem_rvalid && fetch_busy) begin
            next_s.line    = mem_rdata;
            next_s.line_ok = 1'b1;
        end
        // Overlay: off-pattern or disabled pixels pass untouched
        next_s.pix_v = pix_valid;
        next_s.pix   = pix_in;
        if (pix_valid && hit) begin
            case (eff_code)
                hcur_pkg::CODE_PRI: next_s.pix = pri_c;
                hcur_pkg::CODE_SEC: next_s.pix = sec_c;
                hcur_pkg::CODE_TRN: next_s.pix = pix_in;
                default: next_s.pix = three_color_en ? aux_c : inv_c;
            endcase
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    // All state in one register; reset values are all zero
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // ************************************************************
    // Line fetch
    // ************************************************************
    hcur_fetch u_fetch (
        .clk_sys    (clk_sys),
        .arst_n     (arst_n),
        .start_addr (s.start),
        .pitch_2k   (s.pri_hi[hcur_pkg::PITCH_BIT]),
        .line_go    (line_go),
        .line_row   (rel_y[5:0]),
        .mem_rvalid (mem_rvalid),
        .mem_req    (mem_req),
        .mem_addr   (mem_addr),
        .busy       (fetch_busy)
    );

    assign reg_rdata     = s.rdata;
    assign reg_ack       = s.ack;
    assign xfer_wr       = s.xfer_wr;
    assign xfer_data     = s.xfer;
    assign pix_out_valid = s.pix_v;
    assign pix_out       = s.pix;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    // Ack stands one cycle unless a second strobe followed the first
    a_reg_ack: assert property ((reg_wr || reg_rd) |=> reg_ack ##1
        (reg_ack == $past(reg_wr || reg_rd)))
        else $error("access not answered in one cycle");
    a_xfer_word: assert property (reg_wr && reg_addr == hcur_pkg::OFS_XFER |=>
        xfer_wr && xfer_data == $past(reg_wdata))
        else $error("host data word not passed on");
    a_pos_read: assert property (reg_wr && reg_addr == hcur_pkg::OFS_XPOS
        ##1 reg_rd && reg_addr == hcur_pkg::OFS_XPOS && !reg_wr
        |=> reg_rdata == {21'h0, $past(reg_wdata[10:0], 2)})
        else $error("column readback wrong");
    a_cur_off: assert property (pix_valid && !cur_on |=>
        pix_out_valid && pix_out == $past(pix_in))
        else $error("disabled cursor altered the pixel");
    a_transparent: assert property (pix_valid && hit && code == hcur_pkg::CODE_TRN
        |=> pix_out == $past(pix_in))
        else $error("transparent code altered the pixel");
    a_invert: assert property (pix_valid && hit && code == hcur_pkg::CODE_INV
        && !three_color_en && color_mode == hcur_pkg::MODE_8
        |=> pix_out == {16'h0000, ~$past(pix_in[7:0])})
        else $error("inversion wrong");
    a_primary: assert property (pix_valid && hit && code == hcur_pkg::CODE_PRI
        && !color_mode[1] |=> pix_out[7:0] == (($past(exchange_colors))
        ? $past(s.sec_lo[7:0]) : $past(s.pri_lo[7:0])))
        else $error("primary or exchange colour wrong");
    a_row_fetch: assert property (line_start && cur_on && row_in |=> mem_req
        ##0 mem_addr == hcur_pkg::line_addr($past(s.start),
        $past(s.pri_hi[hcur_pkg::PITCH_BIT]), $past(rel_y[5:0])))
        else $error("line fetch missing or misaddressed");
    a_no_fetch_off: assert property (line_start && !cur_on |=> !mem_req)
        else $error("fetch issued while cursor off");

    c_hit_pixel: cover property (pix_valid && hit ##1 pix_out_valid);
    c_line_fetch: cover property (mem_req ##[1:20] mem_rvalid);
    c_xfer: cover property (xfer_wr);
    c_three_col: cover property (pix_valid && hit && three_color_en && code == 2'h3);
endmodule
`default_nettype wire

// *** testbench.sv ***
// Self-checking bench for the cursor block: registers, data port, overlay.
// Assumes the memory model answers each line request within 20 cycles.
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Bench top
// ****************************************************************
module testbench;
    logic         clk_sys = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic         xfer_load = 1'b0, three_color_en = 1'b0, exchange_colors = 1'b0;
    logic         line_start = 1'b0, pix_valid = 1'b0, slow = 1'b0, hit;
    logic [7:0]   reg_addr = 8'h00, sec_color_high = 8'h00;
    logic [31:0]  reg_wdata = '0, xfer_load_data = '0, reg_rdata, xfer_data, d, v;
    logic [1:0]   color_mode = 2'h0;
    logic [10:0]  line_y = '0, pix_x = '0;
    logic [23:0]  aux_color = '0, pix_in = '0, pix_out;
    logic         reg_ack, xfer_wr, mem_req, mem_rvalid, pix_out_valid;
    logic [21:0]  mem_addr;
    logic [127:0] mem_rdata, pat = '0;
    logic [15:0]  st, hot, xp, yp, plo, phi, slo, rv[7];
    logic [5:0]   r;
    logic [7:0]   offs[9] = '{8'h80, 8'h84, 8'h88, 8'h8C, 8'h90, 8'h94, 8'h98, 8'h9C, 8'hA0};
    int           n_mismatch = 0, samples_checked = 0;

    hcur_top DUT (.clk_sys, .arst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
        .reg_ack, .xfer_wr, .xfer_data, .xfer_load, .xfer_load_data, .three_color_en,
        .exchange_colors, .aux_color, .sec_color_high, .color_mode, .mem_req, .mem_addr,
        .mem_rvalid, .mem_rdata, .line_start, .line_y, .pix_valid, .pix_x, .pix_in,
        .pix_out_valid, .pix_out);
    hcur_mem_model mem (.clk_sys, .mem_req, .pat, .slow, .mem_rvalid, .mem_rdata);

    initial begin
        forever #25 clk_sys = ~clk_sys;
    end

    // Read-back mask per offset; unmapped reads as zero
    function automatic logic [31:0] msk(input logic [7:0] a);
        case (a)
            8'h80: msk = 32'hFFFFFFFF;
            8'h88: msk = 32'h00003F3F;
            8'h8C, 8'h90: msk = 32'h000007FF;
            8'h98: msk = 32'h0000C0FF;
            8'hA0: msk = 32'h00000000;
            default: msk = 32'h0000FFFF;
        endcase
    endfunction
    // Expected line address for the chosen pitch
    function automatic logic [21:0] exp_addr();
        if (phi[14]) return {st[15:11], r, st[4:0], 6'h00};
        return {st[15:4], r, 4'h0};
    endfunction
    // Expected overlaid pixel
    function automatic logic [23:0] exp_pix(input logic [10:0] x, input logic [23:0] p);
        logic [12:0] c;
        logic [1:0]  k;
        logic [23:0] o;
        c = {2'h0, x} + {7'h00, hot[5:0]} - {2'h0, xp[10:0]};
        if (!hit || c > 13'd63) return p;
        k = pat[2 * c[5:0] +: 2];
        if (exchange_colors && !k[1]) k[0] = ~k[0];
        case (k)
            2'h0: o = {phi[7:0], plo};
            2'h1: o = {sec_color_high, slo};
            2'h2: return p;
            default: o = three_color_en ? aux_color : ~p;
        endcase
        if (color_mode == 2'h0) return {16'h0000, o[7:0]};
        if (color_mode == 2'h1) return {8'h00, o[15:0]};
        return o;
    endfunction

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One register access; strobe held one cycle, ack checked in its cycle
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= wd;
        reg_wr    <= w;
        reg_rd    <= !w;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1;
        chk("ack", {31'h0, reg_ack}, 32'h1);
        d = reg_rdata;
    endtask
    task automatic wrap_up();
        if (n_mismatch == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // Watchdog: the whole run needs well under 5000 cycles
    initial begin
        repeat (5000) @(posedge clk_sys);
        n_mismatch++;
        wrap_up();
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        void'($urandom(32'h377514cf));
        repeat (8) @(posedge clk_sys);
        arst_n <= 1'b1;
        foreach (offs[i]) begin
            acc(1'b0, offs[i], 32'h0);
            chk("reset", d, 32'h0);
        end
        foreach (offs[i]) begin
            v = $urandom();
            acc(1'b1, offs[i], v);
            if (offs[i] == 8'h80) begin
                chk("xfer_wr", {31'h0, xfer_wr}, 32'h1);
                chk("xfer_data", xfer_data, v);
            end
            acc(1'b0, offs[i], 32'h0);
            chk("readback", d, v & msk(offs[i]));
        end
        // Column write and read on consecutive edges
        v = $urandom();
        @(posedge clk_sys);
        reg_addr  <= 8'h8C;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        chk("back_to_back", reg_rdata, v & 32'h000007FF);
        // Engine loads the port; the host then reads the loaded word
        v = $urandom();
        @(posedge clk_sys);
        xfer_load      <= 1'b1;
        xfer_load_data <= v;
        @(posedge clk_sys);
        xfer_load <= 1'b0;
        acc(1'b0, 8'h80, 32'h0);
        chk("load", d, v);
        // Rounds: pitch alternates, round 5 disabled, round 6 row outside
        for (int k = 0; k < 7; k++) begin
            st  = 16'($urandom());
            hot = 16'($urandom()) & 16'h3F3F;
            xp  = 16'd200 + 16'($urandom() % 800);
            yp  = 16'd200 + 16'($urandom() % 800);
            plo = 16'($urandom());
            slo = 16'($urandom());
            phi = (16'($urandom()) & 16'h00FF) | {k != 5, k[0], 14'h0};
            r   = (k == 3) ? 6'd0 : (k == 4) ? 6'd63 : 6'($urandom());
            pat = {$urandom(), $urandom(), $urandom(), $urandom()};
            rv  = '{st, hot, xp, yp, plo, phi, slo};
            three_color_en  <= 1'($urandom());
            exchange_colors <= 1'($urandom());
            color_mode      <= 2'($urandom());
            sec_color_high  <= 8'($urandom());
            aux_color       <= 24'($urandom());
            slow            <= k[1];
            for (int j = 0; j < 7; j++) acc(1'b1, 8'h84 + 8'(4 * j), {16'h0, rv[j]});
            @(posedge clk_sys);
            line_start <= 1'b1;
            line_y <= yp[10:0] - {5'h0, hot[13:8]} + ((k == 6) ? 11'd64 : {5'h0, r});
            @(posedge clk_sys);
            line_start <= 1'b0;
            #1;
            hit = (k < 5);
            chk("req", {31'h0, mem_req}, {31'h0, hit});
            if (hit) chk("addr", {10'h0, mem_addr}, {10'h0, exp_addr()});
            repeat (20) if (hit && !mem_rvalid) begin
                @(posedge clk_sys);
                #1;
            end
            @(posedge clk_sys);
            // Sweep two columns either side of the pattern window
            for (int x = -2; x < 66; x++) begin
                @(posedge clk_sys);
                pix_x     <= xp[10:0] - {5'h0, hot[5:0]} + 11'(x);
                pix_in    <= 24'($urandom());
                pix_valid <= 1'b1;
                @(posedge clk_sys);
                pix_valid <= 1'b0;
                #1;
                chk("pixel", {7'h0, pix_out_valid, pix_out}, {8'h01, exp_pix(pix_x, pix_in)});
            end
        end
        wrap_up();
    end
endmodule
`default_nettype wire
